// File: verilog/cpm_config_bank.sv
// Control port configuration bank: addressing, pins and audio port
// Functional notes
// [R1] Reset mode: address auto-increments every byte
// [R2] Legacy mode: increment only if address MSB
// [R3] Non-zero book page end: next page, location 8
// [R4] Wrap disabled: page end returns to zero
// [R5] Non-zero book reads: one dummy frame first
// [R6] Book-zero delay bit adds the dummy frame
// [R7] Code 00 read pin, 01 general pin 3
// [R8] Host expects no readback in general-pin use
// [R9] De-emphasis filter enable, off at reset
// [R10] Serial output source: post 0, pre 1
// [R11] Pin 2 direction: input 0, output 1
// [R12] Mute forwarded to power stage when set
// [R13] Pin 0 direction: input 0, output 1
// [R14] Bit clock invert selects aligning edge
// [R15] Bit clock pin master output when set
// [R16] Frame clock pin master output when set
module cpm_config_bank
   import cpm_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe,
   output logic read_pin_is_pin3,
   input wire logic mute_request,
   output logic mute_to_power,
   output logic deemphasis_enable,
   output logic serial_out_source_select,
   output logic pin2_output_enable,
   output logic pin0_output_enable,
   output logic bitclk_invert,
   output logic bitclk_output_enable,
   output logic frameclk_output_enable
);
   cpm_link_if lnk ();
   cpm_state_e state_q;
   logic cs_s1_q, cs_s2_q;
   logic tg_s1_q, tg_s2_q, tg_s3_q;
   logic ev, frame_on, ev_cmd, ev_addr, ev_data;
   logic wr_ev, rd_ev, adv, dly;
   logic [7:0] byte_w;
   logic rd_q, inc_q, skip_q, fetch_q, fetch2_q;
   logic [6:0] addr_q, adv_addr_d;
   logic [7:0] page_q, book_q, adv_page_d;
   logic [7:0] rd_mux_d, rd_reg_q, tx_q, mem_rd;
   logic [7:0] cfg_addr_q, cfg_out_q, cfg_pin_q, cfg_clk_q;
   logic legacy, wrap_dis, b0_dly, book_nz, tgt_mem, mem_we, cfg_page;
   logic [1:0] fn_sel;
   logic miso_oe_q, pin3_q, mute_q;

   cpm_spi_link u_link (
      .spi_sclk(spi_sclk),
      .reset_n(reset_n),
      .spi_cs_n(spi_cs_n),
      .spi_mosi(spi_mosi),
      .spi_miso(spi_miso),
      .lnk(lnk.link)
   );

   cpm_mem u_mem (
      .mclk(mclk),
      .we(mem_we),
      .addr(addr_q),
      .wdata(byte_w),
      .rdata(mem_rd)
   );

   // Two-flop synchronisers for select level and byte toggle
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         tg_s1_q <= 1'b0;
         tg_s2_q <= 1'b0;
         tg_s3_q <= 1'b0;
      end
      else
      begin
         cs_s1_q <= spi_cs_n;
         cs_s2_q <= cs_s1_q;
         tg_s1_q <= lnk.rx_tgl;
         tg_s2_q <= tg_s1_q;
         tg_s3_q <= tg_s2_q;
      end
   end

   // Byte data is held steady for a whole byte after its toggle
   assign byte_w = lnk.rx_byte;
   assign ev = tg_s2_q ^ tg_s3_q;
   assign frame_on = ~cs_s2_q;
   assign ev_cmd = ev & frame_on & (state_q == ST_CMD);
   assign ev_addr = ev & frame_on & (state_q == ST_ADDR);
   assign ev_data = ev & frame_on & (state_q == ST_DATA);
   assign wr_ev = ev_data & ~rd_q;
   assign rd_ev = ev_data & rd_q;

   // Field decode
   assign legacy = cfg_addr_q[BIT_LEGACY_INC];
   assign wrap_dis = cfg_addr_q[BIT_WRAP_DIS];
   assign b0_dly = cfg_addr_q[BIT_B0_DELAY];
   assign fn_sel = cfg_addr_q[BIT_FN_LSB +: 2];
   assign book_nz = book_q != BOOK_ZERO;
   assign cfg_page = ~book_nz & (page_q == PAGE_CFG);
   assign dly = book_nz | b0_dly; // [R5] [R6]
   assign adv = inc_q & (wr_ev | (rd_ev & ~skip_q));
   assign tgt_mem = book_nz & (addr_q != ADDR_PAGE_SEL)
      & (addr_q != ADDR_BOOK_SEL);
   assign mem_we = wr_ev & tgt_mem;

   // Frame sequencer: command, address, then data bytes
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_q <= ST_CMD;
      end
      else if (!frame_on)
      begin
         state_q <= ST_CMD;
      end
      else if (ev)
      begin
         case (state_q)
            ST_CMD: state_q <= ST_ADDR;
            ST_ADDR: state_q <= ST_DATA;
            ST_DATA: state_q <= ST_DATA;
            default: state_q <= ST_CMD;
         endcase
      end
   end

   // Direction, increment mode and dummy-frame flag per frame
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rd_q <= 1'b0;
         inc_q <= 1'b1;
         skip_q <= 1'b0;
      end
      else if (!frame_on)
      begin
         skip_q <= 1'b0;
      end
      else if (ev_cmd)
      begin
         rd_q <= byte_w[BIT_CMD_READ];
      end
      else if (ev_addr)
      begin
         inc_q <= ~legacy | byte_w[BIT_ADDR_INC]; // [R1] [R2]
         skip_q <= rd_q & dly; // [R5] [R6]
      end
      else if (rd_ev)
      begin
         skip_q <= 1'b0;
      end
   end

   // Next location when walking past the page end
   always_comb
   begin
      adv_addr_d = addr_q + 7'h01;
      adv_page_d = page_q;
      if (addr_q == ADDR_LAST)
      begin
         if (book_nz && !wrap_dis)
         begin
            adv_addr_d = ADDR_PAGE_RESTART; // [R3]
            adv_page_d = page_q + 8'h01; // [R3]
         end
         else
         begin
            adv_addr_d = ADDR_ZERO; // [R4]
         end
      end
   end

   // Address pointer
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         addr_q <= ADDR_ZERO;
      end
      else if (ev_addr)
      begin
         addr_q <= byte_w[6:0];
      end
      else if (adv)
      begin
         addr_q <= adv_addr_d; // [R1] [R3] [R4]
      end
   end

   // Page and book selects, visible in every page
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         page_q <= RST_PAGE;
         book_q <= RST_BOOK;
      end
      else
      begin
         if (wr_ev && addr_q == ADDR_PAGE_SEL)
         begin
            page_q <= byte_w;
         end
         else if (adv)
         begin
            page_q <= adv_page_d; // [R3]
         end
         if (wr_ev && addr_q == ADDR_BOOK_SEL)
         begin
            book_q <= byte_w;
         end
      end
   end

   // Configuration registers, reserved bits store what is written
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cfg_addr_q <= RST_ADDR_CFG;
         cfg_out_q <= RST_OUT_CFG;
         cfg_pin_q <= RST_PIN_CFG;
         cfg_clk_q <= RST_CLK_CFG;
      end
      else if (wr_ev && cfg_page)
      begin
         case (addr_q)
            ADDR_ADDR_CFG: cfg_addr_q <= byte_w;
            ADDR_OUT_CFG: cfg_out_q <= byte_w;
            ADDR_PIN_CFG: cfg_pin_q <= byte_w;
            ADDR_CLK_CFG: cfg_clk_q <= byte_w;
            default: cfg_addr_q <= cfg_addr_q;
         endcase
      end
   end

   // Register readback; unmapped locations read zero
   always_comb
   begin
      rd_mux_d = 8'h00;
      if (addr_q == ADDR_PAGE_SEL)
      begin
         rd_mux_d = page_q;
      end
      else if (addr_q == ADDR_BOOK_SEL)
      begin
         rd_mux_d = book_q;
      end
      else if (cfg_page)
      begin
         case (addr_q)
            ADDR_ADDR_CFG: rd_mux_d = cfg_addr_q;
            ADDR_OUT_CFG: rd_mux_d = cfg_out_q;
            ADDR_PIN_CFG: rd_mux_d = cfg_pin_q;
            ADDR_CLK_CFG: rd_mux_d = cfg_clk_q;
            default: rd_mux_d = 8'h00;
         endcase
      end
   end

   // Two-cycle fetch covers the registered memory read
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         fetch_q <= 1'b0;
         fetch2_q <= 1'b0;
         rd_reg_q <= 8'h00;
      end
      else
      begin
         fetch_q <= (ev_addr & rd_q & ~dly) | rd_ev; // [R6]
         fetch2_q <= fetch_q;
         if (fetch_q)
         begin
            rd_reg_q <= rd_mux_d;
         end
      end
   end

   // Transmit byte; zero on the dummy frame after the address
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         tx_q <= 8'h00;
      end
      else if (!frame_on || ev_addr)
      begin
         tx_q <= 8'h00; // [R5]
      end
      else if (fetch2_q)
      begin
         tx_q <= tgt_mem ? mem_rd : rd_reg_q;
      end
   end
   assign lnk.tx_hold = tx_q;

   // Read pin drive and mute forwarding
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         miso_oe_q <= 1'b0;
         pin3_q <= 1'b0;
         mute_q <= 1'b0;
      end
      else
      begin
         miso_oe_q <= frame_on & (fn_sel == FN_MISO); // [R7]
         pin3_q <= fn_sel == FN_PIN3; // [R7]
         mute_q <= cfg_pin_q[BIT_MUTE_FWD] & mute_request; // [R12]
      end
   end

   // Control outputs; read pin and mute via the flops above, the rest straight from the register bits
   assign spi_miso_oe = miso_oe_q;
   assign read_pin_is_pin3 = pin3_q;
   assign mute_to_power = mute_q;
   assign deemphasis_enable = cfg_out_q[BIT_DEEMPH]; // [R9]
   assign serial_out_source_select = cfg_out_q[BIT_SRC_SEL]; // [R10]
   assign pin2_output_enable = cfg_pin_q[BIT_PIN2_OE]; // [R11]
   assign pin0_output_enable = cfg_pin_q[BIT_PIN0_OE]; // [R13]
   assign bitclk_invert = cfg_clk_q[BIT_BCLK_INV]; // [R14]
   assign bitclk_output_enable = cfg_clk_q[BIT_BCLK_OE]; // [R15]
   assign frameclk_output_enable = cfg_clk_q[BIT_FCLK_OE]; // [R16]

   // Checks kept next to the logic they guard
   a_autoinc_default: // [R1]
      assert property (@(posedge mclk) disable iff (!reset_n)
         ev_addr && !legacy |=> inc_q)
      else $error("increment not enabled in default mode");

   a_legacy_msb: // [R2]
      assert property (@(posedge mclk) disable iff (!reset_n)
         ev_addr && legacy |=> inc_q == $past(byte_w[BIT_ADDR_INC]))
      else $error("legacy increment does not follow address msb");

   a_page_carry: // [R3]
      assert property (@(posedge mclk) disable iff (!reset_n)
         adv && book_nz && !wrap_dis && addr_q == ADDR_LAST
         |=> addr_q == ADDR_PAGE_RESTART
         && page_q == $past(page_q) + 8'h01)
      else $error("page end did not move to next page location 8");

   a_page_wrap: // [R4]
      assert property (@(posedge mclk) disable iff (!reset_n)
         adv && book_nz && wrap_dis && addr_q == ADDR_LAST
         |=> addr_q == ADDR_ZERO && $stable(page_q))
      else $error("page end did not wrap in the same page");

   a_book_dummy: // [R5]
      assert property (@(posedge mclk) disable iff (!reset_n)
         ev_addr && rd_q && book_nz
         |=> skip_q && tx_q == 8'h00 && !fetch_q)
      else $error("non-zero book read lacks dummy frame");

   a_book0_direct: // [R6]
      assert property (@(posedge mclk) disable iff (!reset_n)
         ev_addr && rd_q && !book_nz && !b0_dly
         |=> fetch_q ##1 fetch2_q)
      else $error("book zero read not fetched at once");

   a_pin3_quiet: // [R7]
      assert property (@(posedge mclk) disable iff (!reset_n)
         fn_sel != FN_MISO |=> !spi_miso_oe)
      else $error("read pin driven outside its read function");

   a_mute_block: // [R12]
      assert property (@(posedge mclk) disable iff (!reset_n)
         !cfg_pin_q[BIT_MUTE_FWD] |=> !mute_to_power)
      else $error("mute forwarded while forwarding disabled");
endmodule // cpm_config_bank

// File: verilog/cpm_pkg.sv
// Constants and types shared by the control port configuration bank
package cpm_pkg;
   // Register locations inside a page
   localparam logic [6:0] ADDR_PAGE_SEL = 7'h00;
   localparam logic [6:0] ADDR_ADDR_CFG = 7'h06;
   localparam logic [6:0] ADDR_OUT_CFG = 7'h07;
   localparam logic [6:0] ADDR_PIN_CFG = 7'h08;
   localparam logic [6:0] ADDR_CLK_CFG = 7'h09;
   localparam logic [6:0] ADDR_BOOK_SEL = 7'h7F;
   // Address walk limits
   localparam logic [6:0] ADDR_LAST = 7'h7F;
   localparam logic [6:0] ADDR_PAGE_RESTART = 7'h08;
   localparam logic [6:0] ADDR_ZERO = 7'h00;
   localparam logic [7:0] PAGE_CFG = 8'h00;
   localparam logic [7:0] BOOK_ZERO = 8'h00;
   // Values after reset
   localparam logic [7:0] RST_ADDR_CFG = 8'h00;
   localparam logic [7:0] RST_OUT_CFG = 8'h00;
   localparam logic [7:0] RST_PIN_CFG = 8'h00;
   localparam logic [7:0] RST_CLK_CFG = 8'h00;
   localparam logic [7:0] RST_PAGE = 8'h00;
   localparam logic [7:0] RST_BOOK = 8'h00;
   // Field positions
   localparam int BIT_LEGACY_INC = 4;
   localparam int BIT_WRAP_DIS = 3;
   localparam int BIT_B0_DELAY = 2;
   localparam int BIT_FN_LSB = 0;
   localparam int BIT_DEEMPH = 4;
   localparam int BIT_SRC_SEL = 0;
   localparam int BIT_PIN2_OE = 5;
   localparam int BIT_MUTE_FWD = 4;
   localparam int BIT_PIN0_OE = 3;
   localparam int BIT_BCLK_INV = 5;
   localparam int BIT_BCLK_OE = 4;
   localparam int BIT_FCLK_OE = 0;
   // Frame header fields
   localparam int BIT_CMD_READ = 0;
   localparam int BIT_ADDR_INC = 7;
   // Read pin function codes
   localparam logic [1:0] FN_MISO = 2'h0;
   localparam logic [1:0] FN_PIN3 = 2'h1;
   // Backing memory shape
   localparam int MEM_AW = 7;
   localparam int MEM_DW = 8;
   typedef enum logic [1:0] {ST_CMD, ST_ADDR, ST_DATA} cpm_state_e;
endpackage

// File: verilog/cpm_link_if.sv
// Carrier between the serial link end and the register core
interface cpm_link_if;
   logic [7:0] rx_byte;
   logic rx_tgl;
   logic [7:0] tx_hold;
   modport link (output rx_byte, output rx_tgl, input tx_hold);
   modport core (input rx_byte, input rx_tgl, output tx_hold);
endinterface

// File: verilog/cpm_mem.sv
// Byte memory standing in for the non-zero book locations
module cpm_mem
   import cpm_pkg::*;
(
   input wire logic mclk,
   input wire logic we,
   input wire logic [MEM_AW-1:0] addr,
   input wire logic [MEM_DW-1:0] wdata,
   output logic [MEM_DW-1:0] rdata
);
   logic [MEM_DW-1:0] mem_q [2**MEM_AW];

   // Write port, no reset on storage
   always_ff @(posedge mclk)
   begin
      if (we)
      begin
         mem_q[addr] <= wdata;
      end
   end

   // Registered read, one cycle behind the address
   always_ff @(posedge mclk)
   begin
      rdata <= mem_q[addr];
   end
endmodule // cpm_mem

// File: verilog/cpm_spi_link.sv
// Serial control port shifter running on the host's serial clock
module cpm_spi_link
   import cpm_pkg::*;
(
   input wire logic spi_sclk,
   input wire logic reset_n,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   cpm_link_if.link lnk
);
   logic frame_rst_n;
   logic [2:0] tx_pos_q;
   logic [7:0] tx_sh_q;
   logic [2:0] rx_pos_q;
   logic [7:0] rx_sh_q;

   // Deselect clears bit position; the clock may stop between frames
   assign frame_rst_n = reset_n & ~spi_cs_n;

   // Launch on rising edge; tx_hold settles during the byte gap, before the next byte's first edge
   always_ff @(posedge spi_sclk or negedge frame_rst_n)
   begin
      if (!frame_rst_n)
      begin
         tx_pos_q <= 3'h0;
         tx_sh_q <= 8'h00;
         spi_miso <= 1'b0;
      end
      else if (tx_pos_q == 3'h0)
      begin
         spi_miso <= lnk.tx_hold[7];
         tx_sh_q <= {lnk.tx_hold[6:0], 1'b0};
         tx_pos_q <= 3'h1;
      end
      else
      begin
         spi_miso <= tx_sh_q[7];
         tx_sh_q <= {tx_sh_q[6:0], 1'b0};
         tx_pos_q <= tx_pos_q + 3'h1;
      end
   end

   // Sample on falling edge
   always_ff @(negedge spi_sclk or negedge frame_rst_n)
   begin
      if (!frame_rst_n)
      begin
         rx_pos_q <= 3'h0;
         rx_sh_q <= 8'h00;
      end
      else
      begin
         rx_pos_q <= rx_pos_q + 3'h1;
         rx_sh_q <= {rx_sh_q[6:0], spi_mosi};
      end
   end

   // Byte hand-off; toggle survives deselect so no false event
   always_ff @(negedge spi_sclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         lnk.rx_byte <= 8'h00;
         lnk.rx_tgl <= 1'b0;
      end
      else if (rx_pos_q == 3'h7)
      begin
         lnk.rx_byte <= {rx_sh_q[6:0], spi_mosi};
         lnk.rx_tgl <= ~lnk.rx_tgl;
      end
   end
endmodule // cpm_spi_link

// File: dv/cpm_host_model.sv
// Host processor model driving the serial control port
module cpm_host_model
(
   output logic spi_sclk = 1'b0,
   output logic spi_cs_n = 1'b1,
   output logic spi_mosi = 1'b1,
   input wire logic spi_miso,
   input wire logic spi_miso_oe,
   output logic [7:0] rd_byte = 8'h00,
   output logic rd_tgl = 1'b0
);
   timeunit 1ns;
   timeprecision 100ps;

   // Last level seen on the read pin, for the undriven case
   logic last_q = 1'b0;

   // Select falls well ahead of the first edge; odd offset keeps phase free
   task automatic open_frame();
      #3;
      spi_cs_n = 1'b0;
      #100;
   endtask

   // Select held past the last edge, then the data line is let go
   task automatic close_frame();
      #100;
      spi_cs_n = 1'b1;
      spi_mosi = ~spi_mosi;
   endtask

   // One byte MSB first, 64 ns per bit; clock stands low between bytes
   task automatic xfer(input logic [7:0] b, input bit cap);
      logic [7:0] r;
      // Data moves on the rising edge, so the falling edge sees it settled
      for (int i = 7; i >= 0; i--)
      begin
         #32 spi_sclk = 1'b1;
         spi_mosi = b[i];
         #32;
         // A released pin shows no stale data, only the inverse level
         r[i] = spi_miso_oe ? spi_miso : ~last_q;
         last_q = r[i];
         spi_sclk = 1'b0;
      end
      #8 spi_mosi = ~spi_mosi;
      // Gap lets the device fetch the next read byte across domains
      #192;
      if (cap)
      begin
         rd_byte = r;
         rd_tgl = ~rd_tgl;
      end
   endtask
endmodule // cpm_host_model

// File: dv/cpm_config_bank_bench.sv
// Self-checking bench for the control port configuration bank
`define CHK(a, e) \
   begin \
      compares++; \
      if ((a) !== (e)) \
      begin \
         n_mismatch++; \
         $display("Error at %0t: got %h expected %h", $time, (a), (e)); \
      end \
   end

module cpm_config_bank_bench
   import cpm_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic mute_request = 1'b0;
   logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
   logic read_pin_is_pin3, mute_to_power, deemphasis_enable;
   logic serial_out_source_select, pin2_output_enable, pin0_output_enable;
   logic bitclk_invert, bitclk_output_enable, frameclk_output_enable;
   logic [7:0] rd_byte;
   logic rd_tgl;
   int n_mismatch = 0;
   int compares = 0;
   logic [7:0] bq[$];
   logic [7:0] exp_q[$];
   logic [7:0] rv[3] = '{default: 8'h00};
   logic [7:0] m1, m2, b, want;
   logic pr;

   always #5 mclk = ~mclk;

   cpm_config_bank i_cpm_config_bank (
      .mclk(mclk), .reset_n(reset_n), .spi_sclk(spi_sclk),
      .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
      .spi_miso_oe(spi_miso_oe), .read_pin_is_pin3(read_pin_is_pin3),
      .mute_request(mute_request), .mute_to_power(mute_to_power),
      .deemphasis_enable(deemphasis_enable),
      .serial_out_source_select(serial_out_source_select),
      .pin2_output_enable(pin2_output_enable),
      .pin0_output_enable(pin0_output_enable),
      .bitclk_invert(bitclk_invert),
      .bitclk_output_enable(bitclk_output_enable),
      .frameclk_output_enable(frameclk_output_enable));

   cpm_host_model i_cpm_host_model (
      .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
      .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
      .rd_byte(rd_byte), .rd_tgl(rd_tgl));

   // Verdict; a leftover expectation means a read byte never came
   task automatic print_verdict();
      if (exp_q.size() != 0)
         n_mismatch++;
      $display("Mismatches %0d, compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Sends the byte queue as one frame; data bytes of a read are captured
   task automatic frame(input bit rd);
      i_cpm_host_model.open_frame();
      foreach (bq[i])
         i_cpm_host_model.xfer(bq[i], rd && i > 1);
      i_cpm_host_model.close_frame();
      bq.delete();
      repeat (10) @(posedge mclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bq = '{8'h00, a, d};
      frame(1'b0);
   endtask

   // Filler bytes on the data line are random; the device ignores them
   task automatic rd(input logic [7:0] a, input int n);
      bq = '{8'h01, a};
      repeat (n) bq.push_back(8'($urandom));
      frame(1'b1);
   endtask

   task automatic chk_out();
      `CHK(deemphasis_enable, rv[0][BIT_DEEMPH])
      `CHK(serial_out_source_select, rv[0][BIT_SRC_SEL])
      `CHK(pin2_output_enable, rv[1][BIT_PIN2_OE])
      `CHK(pin0_output_enable, rv[1][BIT_PIN0_OE])
      `CHK(bitclk_invert, rv[2][BIT_BCLK_INV])
      `CHK(bitclk_output_enable, rv[2][BIT_BCLK_OE])
      `CHK(frameclk_output_enable, rv[2][BIT_FCLK_OE])
   endtask

   // Empty frame, only to see who owns the read pin; no readback tried
   task automatic pin_frame(input logic oe);
      i_cpm_host_model.open_frame();
      repeat (6) @(posedge mclk);
      `CHK(spi_miso_oe, oe)
      i_cpm_host_model.close_frame();
      repeat (10) @(posedge mclk);
   endtask

   // Oldest expectation per captured byte; time zero is no capture
   always @(rd_tgl)
   begin
      if (reset_n && exp_q.size() == 0)
      begin
         n_mismatch++;
         $display("Error at %0t: got %h expected none", $time, rd_byte);
      end
      else if (reset_n)
      begin
         want = exp_q.pop_front();
         `CHK(rd_byte, want)
      end
   end

   // Watchdog, far beyond the roughly 100 us the sequence needs
   initial
   begin
      #500us;
      n_mismatch++;
      $display("Error at %0t: watchdog expired", $time);
      print_verdict();
   end

   initial
   begin
      void'($urandom(32'h46da));
      repeat (20) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (5) @(posedge mclk);
      // Reset values read in one walk, no delay frame in book zero
      repeat (4) exp_q.push_back(8'h00);
      rd(8'h06, 4);
      chk_out();
      `CHK(read_pin_is_pin3, 1'b0)
      // Three registers in one frame, then the inverted pattern
      for (int k = 0; k < 2; k++)
      begin
         foreach (rv[j])
            rv[j] = k ? ~rv[j] : 8'($urandom);
         bq = '{8'h00, 8'h07, rv[0], rv[1], rv[2]};
         frame(1'b0);
         chk_out();
         foreach (rv[j])
            exp_q.push_back(rv[j]);
         rd(8'h07, 3);
      end
      // Mute forwarding blocked, then passed one clock later
      for (int e = 0; e < 2; e++)
      begin
         rv[1][BIT_MUTE_FWD] = e[0];
         wr(8'h08, rv[1]);
         repeat (16)
         begin
            @(posedge mclk);
            pr = mute_request;
            mute_request <= 1'($urandom);
            #1;
            `CHK(mute_to_power, pr & e[0])
         end
      end
      // Book-zero delay bit: dummy byte first, then the location
      wr(8'h06, 8'h04);
      exp_q.push_back(8'h00);
      exp_q.push_back(rv[0]);
      rd(8'h07, 2);
      // Legacy mode: only the address MSB asks for increment
      wr(8'h06, 8'h10);
      b = 8'($urandom);
      bq = '{8'h00, 8'h07, 8'($urandom), b};
      frame(1'b0);
      rv[0] = b;
      exp_q = '{b, b, b, rv[1]};
      rd(8'h07, 2);
      rd(8'h87, 2);
      wr(8'h06, 8'h00);
      chk_out();
      // Read pin handed to general pin 3 and back
      wr(8'h06, {6'h00, FN_PIN3});
      `CHK(read_pin_is_pin3, 1'b1)
      pin_frame(1'b0);
      wr(8'h06, {6'h00, FN_MISO});
      `CHK(read_pin_is_pin3, 1'b0)
      pin_frame(1'b1);
      // Unmapped place in book zero: write lost, read gives zero
      wr(8'h00, 8'h01);
      wr(8'h07, ~rv[0]);
      exp_q.push_back(8'h00);
      rd(8'h07, 1);
      wr(8'h00, 8'h00);
      chk_out();
      // Page end in book one: wrap disabled first, then next page
      m1 = 8'($urandom);
      m2 = 8'($urandom) | 8'h80;
      wr(8'h06, 8'h08);
      for (int k = 0; k < 2; k++)
      begin
         wr(8'h7F, 8'h01);
         wr(8'h00, 8'h02);
         if (k == 0)
         begin
            wr(8'h7E, m1);
            wr(8'h08, m2);
         end
         exp_q = '{8'h00, m1, 8'h01, k ? m2 : 8'h02};
         rd(8'h7E, 4);
         wr(8'h00, 8'h00);
         wr(8'h7F, 8'h00);
         wr(8'h06, 8'h00);
      end
      chk_out();
      repeat (20) @(posedge mclk);
      print_verdict();
   end
endmodule // cpm_config_bank_bench
